// [rtl/ipcs_master.sv]
// bus master for a two-wire slave with pointer, block write and block read commands
// assumes open-drain SCL and SDA resolved outside; SCL is divided from CLOCK

`timescale 1ns/10ps
`default_nettype none

module ipcs_master #(
    parameter logic [6:0] SLAVE_ADDR = ipcs_pkg::DEFAULT_SLAVE_ADDR,
    parameter logic [7:0] QUARTER_CYC = ipcs_pkg::QUARTER_CYC,
    parameter int BUF_DEPTH = ipcs_pkg::BUF_DEPTH
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    // command request
    input wire logic CMD_VALID,
    output logic CMD_READY,
    input wire ipcs_pkg::ipcs_op_t CMD_OP,
    input wire logic [7:0] CMD_REG,
    input wire logic [7:0] CMD_COUNT,
    // write data stream
    input wire logic WR_VALID,
    output logic WR_READY,
    input wire logic [7:0] WR_DATA,
    // read data stream
    output logic RD_VALID,
    input wire logic RD_READY,
    output logic [7:0] RD_DATA,
    // status
    output logic BUSY,
    output logic DONE,
    output logic NACK,
    output logic REFUSED,
    // serial clock pin
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE_N,
    // serial data pin
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_N
);

    import ipcs_pkg::*;

    // ------------------------------------------------------------
    // controller state
    // ------------------------------------------------------------
    typedef struct packed {
        ipcs_state_t st;
        ipcs_step_t step;
        ipcs_op_t op;
        logic [1:0] qtr;
        logic [7:0] tick;
        logic [2:0] bitn;
        logic [7:0] sh;
        logic [7:0] reg_addr;
        logic [7:0] cnt;
        logic rd_phase;
        logic smp;
        logic scl;
        logic sda;
        logic ptr_set;
        logic done;
        logic nack;
        logic refused;
    } ipcs_ctl_t;

    ipcs_ctl_t q;
    ipcs_ctl_t d;

    logic scl_s;
    logic sda_s;
    logic qend;
    logic rx_mode;
    logic rw_bit;
    logic tx_valid;
    logic tx_pop;
    logic [7:0] tx_data;
    logic rx_push;
    logic rx_ready;
    logic [7:0] cmd_byte;
    logic [7:0] arg_byte;

    // ------------------------------------------------------------
    // pin synchronisers and data buffers
    // ------------------------------------------------------------
    ipcs_sync #(
        .WIDTH(PIN_COUNT),
        .RESET_VAL(PIN_IDLE)
    ) u_sync (
        .clk(CLOCK),
        .reset_n(RESET_N),
        .async_in({SCL_I, SDA_I}),
        .sync_out({scl_s, sda_s})
    );

    // write bytes wait here until the byte engine wants them
    ipcs_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(BUF_DEPTH)
    ) u_tx_buf (
        .clk(CLOCK),
        .reset_n(RESET_N),
        .in_valid(WR_VALID),
        .in_ready(WR_READY),
        .in_data(WR_DATA),
        .out_valid(tx_valid),
        .out_ready(tx_pop),
        .out_data(tx_data)
    );

    // a full read buffer stalls the bus with SCL low, so no byte is lost
    ipcs_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(BUF_DEPTH)
    ) u_rx_buf (
        .clk(CLOCK),
        .reset_n(RESET_N),
        .in_valid(rx_push),
        .in_ready(rx_ready),
        .in_data(q.sh),
        .out_valid(RD_VALID),
        .out_ready(RD_READY),
        .out_data(RD_DATA)
    );

    // ------------------------------------------------------------
    // byte selection helpers
    // ------------------------------------------------------------
    assign qend = (q.tick == QUARTER_CYC - 8'h01);
    assign rx_mode = (q.step == STEP_RDATA);
    // read bit on a plain receive and after the repeated start
    assign rw_bit = (q.rd_phase || q.op == OP_RECV_BYTE) ? RW_READ : RW_WRITE;

    // first byte after the write address
    always_comb begin
        case (q.op)
            OP_SET_PTR: cmd_byte = CODE_POINTER;
            OP_BLOCK_WRITE: cmd_byte = CODE_BLOCK_WRITE;
            OP_BLOCK_READ: cmd_byte = CODE_BLOCK_READ;
            default: cmd_byte = q.reg_addr;
        endcase
    end

    // second byte: register address for the pointer, count for blocks
    assign arg_byte = (q.op == OP_SET_PTR) ? q.reg_addr : q.cnt;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.done = 1'b0;
        d.nack = 1'b0;
        d.refused = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;

        // quarter timer; a released SCL still read low is slave stretching
        if (q.scl && !scl_s) begin
            d.tick = q.tick;
        end else if (qend) begin
            d.tick = 8'h00;
            d.qtr = q.qtr + 2'h1;
        end else begin
            d.tick = q.tick + 8'h01;
        end

        case (q.st)
            ST_IDLE: begin
                d.tick = 8'h00;
                d.qtr = Q_SETUP;
                if (CMD_VALID) begin
                    // block transfers start at the slave pointer, so it must be known
                    if ((CMD_OP == OP_BLOCK_WRITE || CMD_OP == OP_BLOCK_READ) &&
                        !q.ptr_set) begin
                        d.refused = 1'b1;
                    end else begin
                        d.op = CMD_OP;
                        d.reg_addr = CMD_REG;
                        d.cnt = (CMD_OP == OP_RECV_BYTE) ? 8'h01 : CMD_COUNT;
                        d.step = STEP_ADDR;
                        d.rd_phase = 1'b0;
                        d.st = ST_START;
                    end
                end
            end
            ST_START: begin
                // shared by start and repeated start: SDA falls while SCL high
                case (q.qtr)
                    Q_SETUP: d.sda = 1'b1;
                    Q_RISE: d.scl = 1'b1;
                    Q_HIGH: d.sda = 1'b0;
                    default: begin
                        if (qend) begin
                            d.scl = 1'b0;
                            d.st = ST_LOAD;
                        end
                    end
                endcase
            end
            ST_LOAD: begin
                d.tick = 8'h00;
                d.qtr = Q_SETUP;
                d.bitn = MSB_BIT;
                case (q.step)
                    STEP_ADDR: begin
                        d.sh = {SLAVE_ADDR, rw_bit};
                        d.st = ST_BIT;
                    end
                    STEP_CMD: begin
                        d.sh = cmd_byte;
                        d.st = ST_BIT;
                    end
                    STEP_ARG: begin
                        d.sh = arg_byte;
                        d.st = ST_BIT;
                    end
                    STEP_WDATA: begin
                        // SCL stays low until the user supplies the byte
                        if (tx_valid) begin
                            d.sh = tx_data;
                            tx_pop = 1'b1;
                            d.st = ST_BIT;
                        end
                    end
                    default: begin
                        d.sh = 8'h00;
                        d.st = ST_BIT;
                    end
                endcase
            end
            ST_BIT: begin
                // msb first; receive leaves SDA released
                case (q.qtr)
                    Q_SETUP: d.sda = rx_mode ? 1'b1 : q.sh[7];
                    Q_RISE: d.scl = q.scl;
                    Q_HIGH: begin
                        d.scl = 1'b1;
                        if (qend) begin
                            d.smp = sda_s;
                        end
                    end
                    default: begin
                        if (qend) begin
                            d.scl = 1'b0;
                            d.sh = {q.sh[6:0], q.smp};
                            if (q.bitn == 3'h0) begin
                                d.st = ST_ACK;
                            end else begin
                                d.bitn = q.bitn - 3'h1;
                            end
                        end
                    end
                endcase
            end
            ST_ACK: begin
                case (q.qtr)
                    Q_SETUP: begin
                        // master drives ack except on the last byte read
                        d.sda = (rx_mode && q.cnt != 8'h01) ? 1'b0 : 1'b1;
                        if (rx_mode && qend) begin
                            if (rx_ready) begin
                                rx_push = 1'b1;
                            end else begin
                                d.tick = q.tick;
                                d.qtr = q.qtr;
                            end
                        end
                    end
                    Q_RISE: d.scl = q.scl;
                    Q_HIGH: begin
                        d.scl = 1'b1;
                        if (qend) begin
                            d.smp = sda_s;
                        end
                    end
                    default: begin
                        if (qend) begin
                            d.scl = 1'b0;
                            if (rx_mode) begin
                                d.cnt = q.cnt - 8'h01;
                                d.st = (q.cnt == 8'h01) ? ST_STOP : ST_LOAD;
                            end else if (q.smp) begin
                                // no acknowledge from the slave: give up with a stop
                                d.nack = 1'b1;
                                d.st = ST_STOP;
                            end else begin
                                d.st = ST_LOAD;
                                case (q.step)
                                    STEP_ADDR: begin
                                        d.step = (rw_bit == RW_READ) ? STEP_RDATA : STEP_CMD;
                                    end
                                    STEP_CMD: begin
                                        if (q.op == OP_WRITE_REG) begin
                                            d.step = STEP_WDATA;
                                            d.cnt = 8'h01;
                                        end else begin
                                            d.step = STEP_ARG;
                                        end
                                    end
                                    STEP_ARG: begin
                                        if (q.op == OP_SET_PTR) begin
                                            d.ptr_set = 1'b1;
                                            d.st = ST_STOP;
                                        end else if (q.cnt == 8'h00) begin
                                            d.st = ST_STOP;
                                        end else if (q.op == OP_BLOCK_WRITE) begin
                                            d.step = STEP_WDATA;
                                        end else begin
                                            // block read turns round with a repeated start
                                            d.rd_phase = 1'b1;
                                            d.step = STEP_ADDR;
                                            d.st = ST_START;
                                        end
                                    end
                                    default: begin
                                        // exactly the counted bytes, then stop
                                        d.cnt = q.cnt - 8'h01;
                                        if (q.cnt == 8'h01) begin
                                            d.st = ST_STOP;
                                        end
                                    end
                                endcase
                            end
                        end
                    end
                endcase
            end
            default: begin
                // stop: SDA rises while SCL high, last quarter is bus free time
                case (q.qtr)
                    Q_SETUP: d.sda = 1'b0;
                    Q_RISE: d.scl = 1'b1;
                    Q_HIGH: d.sda = 1'b1;
                    default: begin
                        if (qend) begin
                            d.done = 1'b1;
                            d.st = ST_IDLE;
                        end
                    end
                endcase
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            q <= '{st: ST_IDLE, step: STEP_ADDR, op: OP_WRITE_REG,
                   qtr: 2'h0, tick: 8'h00, bitn: 3'h0, sh: 8'h00,
                   reg_addr: 8'h00, cnt: 8'h00, rd_phase: 1'b0, smp: 1'b1,
                   scl: 1'b1, sda: 1'b1, ptr_set: 1'b0, done: 1'b0,
                   nack: 1'b0, refused: 1'b0};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // open drain: pin is pulled low only while its enable is low
    assign SCL_O = 1'b0;
    assign SDA_O = 1'b0;
    assign SCL_OE_N = q.scl;
    assign SDA_OE_N = q.sda;
    assign CMD_READY = (q.st == ST_IDLE);
    assign BUSY = (q.st != ST_IDLE);
    assign DONE = q.done;
    assign NACK = q.nack;
    assign REFUSED = q.refused;

endmodule

`default_nettype wire

// [rtl/ipcs_pkg.sv]
// constants and types for the two-wire pointer-command bus master
// assumes a single system clock; the serial clock is made from it

package ipcs_pkg;

    // ------------------------------------------------------------
    // bus addressing and command codes
    // ------------------------------------------------------------
    localparam logic [6:0] DEFAULT_SLAVE_ADDR = 7'h0D;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic [7:0] CODE_BLOCK_WRITE = 8'hA0;
    localparam logic [7:0] CODE_BLOCK_READ = 8'hA1;
    localparam logic [7:0] CODE_POINTER = 8'hB0;

    // ------------------------------------------------------------
    // timing: one serial bit is four quarters of the serial clock period
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int QUARTERS_PER_BIT = 4;
    // least low/high time, so round the quarter up
    localparam int QUARTER_CYC_INT =
        (SCL_PERIOD_NS + QUARTERS_PER_BIT * CLK_PERIOD_NS - 1) /
        (QUARTERS_PER_BIT * CLK_PERIOD_NS);
    localparam logic [7:0] QUARTER_CYC = 8'(QUARTER_CYC_INT);

    // quarter positions inside a bit slot
    localparam logic [1:0] Q_SETUP = 2'h0;
    localparam logic [1:0] Q_RISE = 2'h1;
    localparam logic [1:0] Q_HIGH = 2'h2;
    localparam logic [1:0] Q_FALL = 2'h3;

    // ------------------------------------------------------------
    // data path sizes and reset values
    // ------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int BUF_DEPTH = 2;
    localparam int PIN_COUNT = 2;
    localparam logic [2:0] MSB_BIT = 3'h7;
    localparam logic [PIN_COUNT-1:0] PIN_IDLE = 2'h3;

    // ------------------------------------------------------------
    // user operations, byte steps and controller states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_WRITE_REG = 3'h0,
        OP_SET_PTR = 3'h1,
        OP_BLOCK_WRITE = 3'h2,
        OP_RECV_BYTE = 3'h3,
        OP_BLOCK_READ = 3'h4
    } ipcs_op_t;

    typedef enum logic [2:0] {
        STEP_ADDR = 3'h0,
        STEP_CMD = 3'h1,
        STEP_ARG = 3'h2,
        STEP_WDATA = 3'h3,
        STEP_RDATA = 3'h4
    } ipcs_step_t;

    // gray along idle, start, load, bit, ack, stop, idle
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_LOAD = 3'b011,
        ST_BIT = 3'b010,
        ST_ACK = 3'b110,
        ST_STOP = 3'b100
    } ipcs_state_t;

endpackage

// [rtl/ipcs_sync.sv]
// three-stage synchroniser for pin inputs with agree filter
// assumes inputs are asynchronous to CLOCK; reset is synchronous active low

`timescale 1ns/10ps
`default_nettype none

module ipcs_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // asynchronous in, filtered out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] o;
    } ipcs_sync_t;

    ipcs_sync_t q;
    ipcs_sync_t d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // s1 feeds only s2; output moves when s2 and s3 agree
    always_comb begin
        d = q;
        d.s1 = async_in;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.o = (q.s2 & q.s3) | (q.o & (q.s2 | q.s3));
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= {4{RESET_VAL}};
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.o;

endmodule

`default_nettype wire

// [rtl/ipcs_fifo.sv]
// small valid/ready buffer, default two entries
// assumes both sides on the same clock; reset is synchronous active low

`timescale 1ns/10ps
`default_nettype none

module ipcs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } ipcs_fifo_t;

    ipcs_fifo_t q;
    ipcs_fifo_t d;
    logic push;
    logic pop;

    // honest flags straight from the count
    assign in_ready = (q.cnt != FULL_CNT);
    assign out_valid = (q.cnt != '0);
    assign out_data = q.mem[q.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ------------------------------------------------------------
    // pointer and count update
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = (q.wp == LAST_PTR) ? '0 : q.wp + AW'(1);
        end
        if (pop) begin
            d.rp = (q.rp == LAST_PTR) ? '0 : q.rp + AW'(1);
        end
        if (push && !pop) begin
            d.cnt = q.cnt + CW'(1);
        end else if (pop && !push) begin
            d.cnt = q.cnt - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule

`default_nettype wire

// [rtl/ipcs_fix_note.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [bench/ipcs_master_sva.sv]
// checker for the two-wire pointer-command bus master
// sees only the top module's ports; bound at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module ipcs_master_sva
    import ipcs_pkg::*;
(
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    // command and status
    input wire logic CMD_VALID,
    input wire logic CMD_READY,
    input wire ipcs_pkg::ipcs_op_t CMD_OP,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic NACK,
    input wire logic REFUSED,
    // read stream and pins
    input wire logic RD_VALID,
    input wire logic RD_READY,
    input wire logic [7:0] RD_DATA,
    input wire logic SCL_OE_N,
    input wire logic SDA_OE_N
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // a taken command either runs or is refused at once
    sequence s_take; CMD_VALID && CMD_READY; endsequence
    sequence s_quiet; !BUSY && SCL_OE_N && SDA_OE_N; endsequence
    take_runs_a: assert property (s_take |=> BUSY || REFUSED)
        else $error("taken command neither ran nor was refused");
    refuse_block_a: assert property (REFUSED |-> $past(CMD_OP) inside {OP_BLOCK_WRITE, OP_BLOCK_READ})
        else $error("refusal of a non-block command");
    refuse_quiet_a: assert property (REFUSED |-> s_quiet)
        else $error("refused command touched the bus");
    busy_ready_a: assert property (BUSY |-> !CMD_READY)
        else $error("ready while busy");
    end_done_a: assert property ($fell(BUSY) |-> DONE)
        else $error("busy ended without done");
    idle_release_a: assert property (!BUSY |-> SCL_OE_N && SDA_OE_N)
        else $error("pin pulled while idle");
    nack_stop_a: assert property (NACK |-> ##[1:1000] DONE)
        else $error("no stop after slave nack");
    rd_hold_a: assert property (RD_VALID && !RD_READY |=> RD_VALID && $stable(RD_DATA))
        else $error("read byte lost under stall");
    done_pulse_a: assert property (DONE |-> s_quiet ##1 !DONE)
        else $error("done not a single idle pulse");
endmodule
bind ipcs_master ipcs_master_sva i_sva (.CLOCK, .RESET_N, .CMD_VALID, .CMD_READY, .CMD_OP,
    .BUSY, .DONE, .NACK, .REFUSED, .RD_VALID, .RD_READY, .RD_DATA, .SCL_OE_N, .SDA_OE_N);
`default_nettype wire

// [bench/ipcs_dev_model.sv]
// behavioural two-wire slave with pointer, block write and block read
// assumes resolved wires with pull-ups; pulls lines low through outputs
`timescale 1ns/10ps
`default_nettype none
module ipcs_dev_model #(
    parameter logic [6:0] ADDR = 7'h0D
) (
    // resolved bus lines
    input wire logic scl,
    input wire logic sda,
    // commanded misbehaviour
    input wire logic deaf,
    input wire logic slow,
    // pulls toward low
    output logic sda_low,
    output logic scl_low
);
    logic [7:0] mem [256];
    logic [7:0] sh, tx, cmd, ptr;
    logic rd, mack;
    int cnt, nb;
    initial begin
        sda_low = 0; scl_low = 0; cnt = 0; nb = 0; rd = 0; cmd = 0; ptr = 0;
    end
    // start keeps cmd so a repeated start still knows a block read
    always @(negedge sda) if (scl) begin
        cnt = 0; nb = 0; rd = 0;
    end
    always @(posedge sda) if (scl) cmd = 0;
    // sample bits, then the master's acknowledge
    always @(posedge scl) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        else mack = !sda;
        cnt++;
    end
    // drive on falling clock; ack held through the ninth high phase
    always @(negedge scl) begin
        if (cnt == 8 && (nb == 0 || !rd)) begin
            sda_low = !deaf && (nb > 0 || sh[7:1] == ADDR);
            if (nb == 0) rd = sh[0];
            else if (nb == 1) cmd = sh;
            else if (cmd == 8'hB0) ptr = sh;
            else if (cmd == 8'hA0) begin
                if (nb > 2) begin
                    mem[ptr] = sh;
                    ptr++;
                end
            end else if (nb == 2 && cmd != 8'hA1) mem[cmd] = sh;
        end else if (cnt == 8) sda_low = 0;
        else if (cnt == 9) begin
            cnt = 0;
            sda_low = 0;
            if (rd && (nb == 0 || mack)) begin
                tx = mem[ptr];
                if (cmd == 8'hA1) ptr++;
                sda_low = !tx[7];
            end
            nb++;
        end else if (rd && nb > 0) sda_low = !tx[7 - cnt];
        // slow answers stretch the clock low
        if (slow) begin
            scl_low = 1;
            #200 scl_low = 0;
        end
    end
endmodule
`default_nettype wire

// [bench/ipcs_master_tb_top.sv]
// self-checking bench for the pointer-command bus master
// assumes the behavioural slave model and wired-and pins with pull-ups
`timescale 1ns/10ps
`default_nettype none
module ipcs_master_tb_top;
    import ipcs_pkg::*;
    logic CLOCK = 0, RESET_N = 0, CMD_VALID = 0, WR_VALID = 0, RD_READY = 0;
    logic deaf = 0, slow = 0, nk, rf, CMD_READY, WR_READY, RD_VALID, BUSY, DONE, NACK, REFUSED;
    logic SCL_OE_N, SDA_OE_N, sda_low, scl_low;
    ipcs_op_t CMD_OP = OP_WRITE_REG;
    logic [7:0] CMD_REG = 0, CMD_COUNT = 0, WR_DATA = 0, RD_DATA;
    logic [7:0] rq[$];
    int mismatches = 0, n_compared = 0;
    wire scl = SCL_OE_N & !scl_low;
    wire sda = SDA_OE_N & !sda_low;
    always #4 CLOCK = ~CLOCK;
    ipcs_master #(.QUARTER_CYC(8'h03)) i_dut (.CLOCK, .RESET_N, .CMD_VALID, .CMD_READY,
        .CMD_OP, .CMD_REG, .CMD_COUNT, .WR_VALID, .WR_READY, .WR_DATA, .RD_VALID, .RD_READY,
        .RD_DATA, .BUSY, .DONE, .NACK, .REFUSED, .SCL_I(scl), .SCL_O(), .SCL_OE_N,
        .SDA_I(sda), .SDA_O(), .SDA_OE_N);
    ipcs_dev_model i_dev (.scl, .sda, .deaf, .slow, .sda_low, .scl_low);
    // status pulses latched, read bytes collected
    always @(posedge CLOCK) begin
        if (NACK) nk <= 1;
        if (REFUSED) rf <= 1;
        if (RD_VALID && RD_READY) rq.push_back(RD_DATA);
    end
    task automatic step; @(posedge CLOCK); #1; endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // one command, waited on under a bound
    task automatic run(ipcs_op_t op, logic [7:0] r, logic [7:0] c);
        int n;
        nk = 0; rf = 0; rq.delete();
        CMD_OP = op; CMD_REG = r; CMD_COUNT = c; CMD_VALID = 1;
        step;
        CMD_VALID = 0;
        for (n = 0; n < 30000 && DONE !== 1 && rf !== 1; n++) step;
        if (n == 30000) begin mismatches++; give_verdict; end
    endtask
    // valid drops for one edge after each byte, so no byte is pushed twice
    task automatic feed(logic [7:0] b);
        int n;
        WR_DATA = b; WR_VALID = 1;
        for (n = 0; n < 30000 && WR_READY !== 1; n++) step;
        if (n == 30000) begin mismatches++; give_verdict; end
        step;
        WR_VALID = 0;
        step;
    endtask
    task automatic t_refuse;
        run(OP_BLOCK_WRITE, 0, 1); chk("refused", 1, {7'h0, rf});
        run(OP_BLOCK_READ, 0, 1); chk("refused", 1, {7'h0, rf});
    endtask
    task automatic t_write;
        fork run(OP_WRITE_REG, 8'h10, 0); feed(8'h5A); join
        chk("reg 10", 8'h5A, i_dev.mem[8'h10]);
    endtask
    task automatic t_block_write;
        run(OP_SET_PTR, 8'h20, 0);
        fork run(OP_BLOCK_WRITE, 0, 3); begin feed(8'h11); feed(8'h22); feed(8'h33); end join
        for (int i = 0; i < 3; i++) chk("block reg", 8'h11 * (i + 1), i_dev.mem[8'h20 + i]);
        chk("nack", 0, {7'h0, nk});
    endtask
    task automatic t_recv;
        RD_READY = 1;
        run(OP_SET_PTR, 8'h21, 0);
        run(OP_RECV_BYTE, 0, 0); chk("recv", 8'h22, rq[0]);
        run(OP_RECV_BYTE, 0, 0); chk("recv again", 8'h22, rq[0]);
    endtask
    // stalled reader fills the buffer; slave stretches meanwhile
    task automatic t_block_read;
        run(OP_SET_PTR, 8'h20, 0);
        RD_READY = 0; slow = 1;
        fork run(OP_BLOCK_READ, 0, 3); begin repeat (3000) step; RD_READY = 1; end join
        slow = 0;
        chk("read count", 3, 8'(rq.size()));
        for (int i = 0; i < 3; i++) chk("block read", 8'h11 * (i + 1), rq[i]);
    endtask
    task automatic t_nack;
        deaf = 1;
        fork run(OP_WRITE_REG, 8'h30, 0); feed(8'h77); join
        chk("nack", 1, {7'h0, nk});
    endtask
    initial begin
        repeat (20) @(posedge CLOCK);
        #1 RESET_N = 1;
        t_refuse;
        t_write;
        t_block_write;
        t_recv;
        t_block_read;
        t_nack;
        give_verdict;
    end
endmodule
`default_nettype wire
